/* File: hdl/cars_core_regs.sv */
// architected register set: integer, float, condition, status, machine state, segments
//
// Summary of operation
// - 32 general registers feed integer operands
// - thirty-two 32-bit float registers
// - double-precision request raises trap, no execution
// - condition register: eight independent 4-bit fields
// - float status/control word holds ieee bits
// - machine state saved on exception, restorable
// - sixteen segments, main data, shadow instruction
// - segment write updates both copies together
// - privileged writes only in supervisor mode
// - two sources, separate target, optional immediate
// - privilege taken from machine state bit
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "cars_consts.svh"
module cars_core_regs
#(
    parameter int GPR_COUNT = 32,
    parameter int FPR_COUNT = 32,
    parameter int SEG_COUNT = 16,
    localparam int GW = $clog2(GPR_COUNT),
    localparam int FW = $clog2(FPR_COUNT),
    localparam int SW = $clog2(SEG_COUNT)
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [GW-1:0] gpr_ra_in,
    input wire logic [GW-1:0] gpr_rb_in,
    input wire cars_pkg::cars_src_t src_b_sel_in,
    input wire logic [31:0] imm_in,
    output logic [31:0] op_a_out,
    output logic [31:0] op_b_out,
    input wire logic gpr_we_in,
    input wire logic [GW-1:0] gpr_rt_in,
    input wire logic [31:0] gpr_wd_in,
    input wire logic [FW-1:0] fpr_ra_in,
    input wire logic [FW-1:0] fpr_rb_in,
    output logic [31:0] fpr_a_out,
    output logic [31:0] fpr_b_out,
    input wire logic fpr_we_in,
    input wire logic [FW-1:0] fpr_rt_in,
    input wire logic [31:0] fpr_wd_in,
    input wire logic fp_valid_in,
    input wire logic fp_double_in,
    output logic fp_trap_out,
    input wire logic [7:0] cr_we_in,
    input wire logic [31:0] cr_wd_in,
    output wire logic [31:0] cr_out,
    input wire logic float_status_ctrl_we_in,
    input wire logic [31:0] float_status_ctrl_wd_in,
    output logic [31:0] float_status_ctrl_out,
    input wire logic exc_take_in,
    input wire logic [31:0] msr_exc_in,
    input wire logic exc_return_in,
    input wire logic msr_we_in,
    input wire logic [31:0] msr_wd_in,
    output logic [31:0] msr_out,
    output logic supervisor_out,
    input wire logic sr_we_in,
    input wire logic [SW-1:0] sr_idx_in,
    input wire logic [31:0] sr_wd_in,
    input wire logic [SW-1:0] iseg_idx_in,
    input wire logic [SW-1:0] dseg_idx_in,
    output logic [31:0] iseg_out,
    output logic [31:0] dseg_out,
    output logic priv_fault_out
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [31:0] general_regs [GPR_COUNT];
    logic [31:0] float_regs [FPR_COUNT];
    logic [3:0] condition_reg [8];
    logic [31:0] msr_save;
    logic [31:0] next_msr;
    logic [31:0] seg_main [SEG_COUNT];
    logic [31:0] seg_shadow [SEG_COUNT];
    logic stat_trap;
    logic stat_priv;
    logic [31:0] rd_mux;
    logic sup;
    logic wr_cr, wr_float_status_ctrl, wr_msr, wr_save, wr_stat, wr_seg;
    logic priv_req;
    logic seg_we;
    logic [SW-1:0] seg_idx;
    logic [31:0] seg_wd;
    logic dp_event;
    logic [SEG_COUNT-1:0] seg_filled;

    // reset leaves through two flops so release is clean on mclk_in
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    assign sup = !msr_out[`CARS_MSR_PR];
    assign wr_cr = reg_wr_in && reg_addr_in == `CARS_ADDR_CR;
    assign wr_float_status_ctrl = reg_wr_in && reg_addr_in == `CARS_ADDR_FLOAT_STATUS_CTRL;
    assign wr_msr = reg_wr_in && reg_addr_in == `CARS_ADDR_MSR;
    assign wr_save = reg_wr_in && reg_addr_in == `CARS_ADDR_SAVE;
    assign wr_stat = reg_wr_in && reg_addr_in == `CARS_ADDR_STAT;
    assign wr_seg = reg_wr_in && reg_addr_in[7:6] == `CARS_SEG_PAGE;
    assign priv_req = msr_we_in || sr_we_in || wr_msr || wr_save || wr_seg;
    assign dp_event = fp_valid_in && fp_double_in;

    // general registers; read gives the value before a same-cycle write
    always_ff @(posedge mclk_in)
    begin
        if (gpr_we_in)
            general_regs[gpr_rt_in] <= gpr_wd_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_a_out <= `CARS_WORD_RST;
            op_b_out <= `CARS_WORD_RST;
        end
        else
        begin
            op_a_out <= general_regs[gpr_ra_in];
            if (src_b_sel_in == cars_pkg::CARS_SRC_IMM)
                op_b_out <= imm_in;
            else
                op_b_out <= general_regs[gpr_rb_in];
        end
    end

    // double requests never land in the float file
    always_ff @(posedge mclk_in)
    begin
        if (fpr_we_in && !fp_double_in)
            float_regs[fpr_rt_in] <= fpr_wd_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fpr_a_out <= `CARS_WORD_RST;
            fpr_b_out <= `CARS_WORD_RST;
            fp_trap_out <= 1'b0;
        end
        else
        begin
            fpr_a_out <= float_regs[fpr_ra_in];
            fpr_b_out <= float_regs[fpr_rb_in];
            fp_trap_out <= dp_event;
        end
    end

    // core field update wins over a software write of the same field
    genvar f;
    for (f = 0; f < 8; f++)
    begin : g_cr
        always_ff @(posedge mclk_in or negedge rst_n)
        begin
            if (!rst_n)
                condition_reg[f] <= 4'h0;
            else if (cr_we_in[f])
                condition_reg[f] <= cr_wd_in[f*`CARS_FIELD_W +: `CARS_FIELD_W];
            else if (wr_cr)
                condition_reg[f] <= reg_wdata_in[f*`CARS_FIELD_W +: `CARS_FIELD_W];
        end
        assign cr_out[f*`CARS_FIELD_W +: `CARS_FIELD_W] = condition_reg[f];
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            float_status_ctrl_out <= `CARS_WORD_RST;
        else if (float_status_ctrl_we_in)
            float_status_ctrl_out <= float_status_ctrl_wd_in;
        else if (wr_float_status_ctrl)
            float_status_ctrl_out <= reg_wdata_in;
    end

    // exception entry beats return, which beats privileged writes
    always_comb
    begin
        next_msr = msr_out;
        if (exc_take_in)
            next_msr = msr_exc_in;
        else if (exc_return_in)
            next_msr = msr_save;
        else if (msr_we_in && sup)
            next_msr = msr_wd_in;
        else if (wr_msr && sup)
            next_msr = reg_wdata_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msr_out <= `CARS_MSR_RST;
            supervisor_out <= 1'b1;
        end
        else
        begin
            msr_out <= next_msr;
            supervisor_out <= !next_msr[`CARS_MSR_PR];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            msr_save <= `CARS_MSR_RST;
        else if (exc_take_in)
            msr_save <= msr_out;
        else if (wr_save && sup)
            msr_save <= reg_wdata_in;
    end

    // core move to segment wins a tie with a software write
    assign seg_we = sup && (sr_we_in || wr_seg);
    assign seg_idx = sr_we_in ? sr_idx_in : reg_addr_in[SW+1:2];
    assign seg_wd = sr_we_in ? sr_wd_in : reg_wdata_in;

    // two copies trade area for an extra lookup port
    always_ff @(posedge mclk_in)
    begin
        if (seg_we)
            seg_main[seg_idx] <= seg_wd;
    end

    always_ff @(posedge mclk_in)
    begin
        if (seg_we)
            seg_shadow[seg_idx] <= seg_wd;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iseg_out <= `CARS_WORD_RST;
            dseg_out <= `CARS_WORD_RST;
        end
        else
        begin
            iseg_out <= seg_shadow[iseg_idx_in];
            dseg_out <= seg_main[dseg_idx_in];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            priv_fault_out <= 1'b0;
        else
            priv_fault_out <= priv_req && !sup;
    end

    // sticky flags: a new event wins over a write-one clear
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            stat_trap <= 1'b0;
        else if (dp_event)
            stat_trap <= 1'b1;
        else if (wr_stat && reg_wdata_in[`CARS_STAT_TRAP])
            stat_trap <= 1'b0;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            stat_priv <= 1'b0;
        else if (priv_req && !sup)
            stat_priv <= 1'b1;
        else if (wr_stat && reg_wdata_in[`CARS_STAT_PRIV])
            stat_priv <= 1'b0;
    end

    always_comb
    begin
        rd_mux = `CARS_WORD_RST;
        if (reg_addr_in[7:6] == `CARS_SEG_PAGE)
            rd_mux = seg_main[reg_addr_in[SW+1:2]];
        else if (reg_addr_in == `CARS_ADDR_CR)
            rd_mux = cr_out;
        else if (reg_addr_in == `CARS_ADDR_FLOAT_STATUS_CTRL)
            rd_mux = float_status_ctrl_out;
        else if (reg_addr_in == `CARS_ADDR_MSR)
            rd_mux = msr_out;
        else if (reg_addr_in == `CARS_ADDR_SAVE)
            rd_mux = msr_save;
        else if (reg_addr_in == `CARS_ADDR_STAT)
        begin
            rd_mux[`CARS_STAT_TRAP] = stat_trap;
            rd_mux[`CARS_STAT_PRIV] = stat_priv;
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_out <= `CARS_WORD_RST;
        else if (reg_rd_in)
            reg_rdata_out <= rd_mux;
        else
            reg_rdata_out <= `CARS_WORD_RST;
    end

    // copy check helper: entries never written hold unknowns
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            seg_filled <= {SEG_COUNT{1'b0}};
        else if (seg_we)
            seg_filled[seg_idx] <= 1'b1;
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n);

    sequence s_gpr_wr;
        gpr_we_in && gpr_rt_in == gpr_ra_in;
    endsequence
    sequence s_gpr_hold;
        $stable(gpr_ra_in) && !gpr_we_in;
    endsequence
    property p_gpr_rw;
        s_gpr_wr ##1 s_gpr_hold |=> op_a_out == $past(gpr_wd_in, 2);
    endproperty
    a_gpr_rw: assert property (p_gpr_rw) else $error("gpr write not read back");

    property p_fpr_rw;
        fpr_we_in && !fp_double_in && fpr_rt_in == fpr_ra_in
            ##1 ($stable(fpr_ra_in) && !fpr_we_in) |=> fpr_a_out == $past(fpr_wd_in, 2);
    endproperty
    a_fpr_rw: assert property (p_fpr_rw) else $error("fpr write not read back");

    property p_dp_trap;
        fp_trap_out == $past(fp_valid_in && fp_double_in);
    endproperty
    a_dp_trap: assert property (p_dp_trap) else $error("trap does not follow double request");

    property p_cr_field;
        cr_we_in[0] && !cr_we_in[7] && !wr_cr
            |=> cr_out[3:0] == $past(cr_wd_in[3:0]) && $stable(cr_out[31:28]);
    endproperty
    a_cr_field: assert property (p_cr_field) else $error("cr field update wrong");

    property p_float_status_ctrl;
        float_status_ctrl_we_in |=> float_status_ctrl_out == $past(float_status_ctrl_wd_in);
    endproperty
    a_float_status_ctrl: assert property (p_float_status_ctrl) else $error("float_status_ctrl not written");

    property p_msr_save;
        exc_take_in ##1 (!exc_take_in && !wr_save && exc_return_in) |=> msr_out == $past(msr_out, 2);
    endproperty
    a_msr_save: assert property (p_msr_save) else $error("msr not restored");

    property p_seg_copy;
        iseg_idx_in == dseg_idx_in && seg_filled[iseg_idx_in] |=> iseg_out == dseg_out;
    endproperty
    a_seg_copy: assert property (p_seg_copy) else $error("segment copies differ");

    property p_priv;
        msr_we_in && !sup && !exc_take_in && !exc_return_in |=> priv_fault_out && $stable(msr_out);
    endproperty
    a_priv: assert property (p_priv) else $error("user write reached msr");

    property p_imm;
        src_b_sel_in == cars_pkg::CARS_SRC_IMM |=> op_b_out == $past(imm_in);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate not selected");

    property p_pr_bit;
        supervisor_out == !msr_out[`CARS_MSR_PR];
    endproperty
    a_pr_bit: assert property (p_pr_bit) else $error("privilege out of step with msr");

    property p_seg_lookup;
        sr_we_in && sup && !exc_take_in ##1 (iseg_idx_in == $past(sr_idx_in) && !sr_we_in
            && !wr_seg && dseg_idx_in == $past(sr_idx_in)) |=> iseg_out == $past(sr_wd_in, 2)
            && dseg_out == $past(sr_wd_in, 2);
    endproperty
    a_seg_lookup: assert property (p_seg_lookup) else $error("segment lookup stale");
endmodule

/* File: hdl/cars_consts.svh */
// register offsets, field positions and reset values of the architected register set
`ifndef CARS_CONSTS_SVH
`define CARS_CONSTS_SVH
`define CARS_ADDR_CR 8'h00
`define CARS_ADDR_FLOAT_STATUS_CTRL 8'h04
`define CARS_ADDR_MSR 8'h08
`define CARS_ADDR_SAVE 8'h0c
`define CARS_ADDR_STAT 8'h10
`define CARS_SEG_PAGE 2'h1
`define CARS_MSR_PR 14
`define CARS_MSR_RST 32'h0000_0000
`define CARS_WORD_RST 32'h0000_0000
`define CARS_FIELD_W 4
`define CARS_STAT_TRAP 0
`define CARS_STAT_PRIV 1
`endif

/* File: hdl/cars_pkg.sv */
// types shared by the architected register set
package cars_pkg;
    typedef enum logic {CARS_SRC_REG, CARS_SRC_IMM} cars_src_t;
endpackage

/* File: dv/cars_exec_model.sv */
// execution unit model: streams one integer result per cycle into every general register
`timescale 1ns/1ps
module cars_exec_model
(
    input wire logic mclk_in,
    input wire logic run_in,
    input wire logic [31:0] key_in,
    output logic gpr_we_out,
    output logic [4:0] gpr_rt_out,
    output logic [31:0] gpr_wd_out,
    output logic done_out
);
    logic [5:0] cnt;
    initial cnt = 6'h00;
    initial gpr_we_out = 1'b0;
    assign done_out = cnt[5];
    // back-to-back results, no gap, to stress the write port
    always @(posedge mclk_in)
    begin
        gpr_we_out <= run_in && !cnt[5];
        gpr_rt_out <= cnt[4:0];
        gpr_wd_out <= key_in + {27'h0, cnt[4:0]};
        if (run_in && !cnt[5])
        begin
            cnt <= cnt + 6'h01;
        end
    end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the architected register set
`timescale 1ns/1ps
`include "cars_consts.svh"
module testbench;
    localparam logic [31:0] USER = 32'h1 << `CARS_MSR_PR;
    localparam logic [31:0] STAT_ALL = (32'h1 << `CARS_STAT_TRAP) | (32'h1 << `CARS_STAT_PRIV);
    logic mclk_in = 1'b0, arst_n_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, run = 1'b0;
    logic fpr_we_in = 1'b0, fp_valid_in = 1'b0, fp_double_in = 1'b0, float_status_ctrl_we_in = 1'b0;
    logic exc_take_in = 1'b0, exc_return_in = 1'b0, msr_we_in = 1'b0, sr_we_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, cr_we_in = 8'h00;
    logic [4:0] gpr_ra_in = 5'h00, gpr_rb_in = 5'h00, fpr_ra_in = 5'h00;
    logic [4:0] fpr_rb_in = 5'h00, fpr_rt_in = 5'h00;
    logic [3:0] sr_idx_in = 4'h0, iseg_idx_in = 4'h0, dseg_idx_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, imm_in = 32'h0, fpr_wd_in = 32'h0, cr_wd_in = 32'h0;
    logic [31:0] float_status_ctrl_wd_in = 32'h0, msr_exc_in = 32'h0, msr_wd_in = 32'h0, sr_wd_in = 32'h0;
    logic [31:0] key = 32'h0, exp;
    logic [31:0] fv [32];
    logic [31:0] sv [16];
    cars_pkg::cars_src_t src_b_sel_in = cars_pkg::CARS_SRC_REG;
    wire logic [31:0] reg_rdata_out, op_a_out, op_b_out, fpr_a_out, fpr_b_out, cr_out;
    wire logic [31:0] float_status_ctrl_out, msr_out, iseg_out, dseg_out, gpr_wd;
    wire logic fp_trap_out, supervisor_out, priv_fault_out, gpr_we, done;
    wire logic [4:0] gpr_rt;
    int seed = 32'hbf2fb252;
    int num_errors = 0;
    int checks_done = 0;

    always #4 mclk_in = ~mclk_in;

    cars_core_regs cars_core_regs_i (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .gpr_ra_in, .gpr_rb_in, .src_b_sel_in,
        .imm_in, .op_a_out, .op_b_out, .gpr_we_in(gpr_we), .gpr_rt_in(gpr_rt),
        .gpr_wd_in(gpr_wd), .fpr_ra_in, .fpr_rb_in, .fpr_a_out, .fpr_b_out, .fpr_we_in,
        .fpr_rt_in, .fpr_wd_in, .fp_valid_in, .fp_double_in, .fp_trap_out, .cr_we_in,
        .cr_wd_in, .cr_out, .float_status_ctrl_we_in, .float_status_ctrl_wd_in, .float_status_ctrl_out, .exc_take_in,
        .msr_exc_in, .exc_return_in, .msr_we_in, .msr_wd_in, .msr_out, .supervisor_out,
        .sr_we_in, .sr_idx_in, .sr_wd_in, .iseg_idx_in, .dseg_idx_in, .iseg_out, .dseg_out,
        .priv_fault_out);
    cars_exec_model cars_exec_model_i (.mclk_in, .run_in(run), .key_in(key),
        .gpr_we_out(gpr_we), .gpr_rt_out(gpr_rt), .gpr_wd_out(gpr_wd), .done_out(done));

    function automatic logic [31:0] crm(input logic [31:0] r, input logic [7:0] m,
        input logic [31:0] d);
        for (int f = 0; f < 8; f++)
        begin
            if (m[f])
            begin
                r[4*f +: 4] = d[4*f +: 4];
            end
        end
        return r;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
        end
    endtask

    // one strobe cycle; a read compares the word in the following cycle only
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] want);
        @(posedge mclk_in);
        reg_wr_in <= wr;
        reg_rd_in <= !wr;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        if (!wr)
        begin
            chk(reg_rdata_out, want);
        end
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && checks_done > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk_in);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        // a real falling edge at time zero, so reset is known before the first clock
        arst_n_in <= 1'b0;
        repeat (12) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        key <= $random(seed);
        run <= 1'b1;
        #1;
        chk({31'h0, supervisor_out}, 32'h1);
        chk(msr_out, `CARS_MSR_RST);
        for (int k = 0; k < 60 && done !== 1'b1; k++)
        begin
            @(posedge mclk_in);
        end
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk_in);
            gpr_ra_in <= 5'(i);
            gpr_rb_in <= 5'(31 - i);
            @(posedge mclk_in);
            #1;
            chk(op_a_out, key + 32'(i));
            chk(op_b_out, key + 32'(31 - i));
        end
        @(posedge mclk_in);
        imm_in <= $random(seed);
        src_b_sel_in <= cars_pkg::CARS_SRC_IMM;
        @(posedge mclk_in);
        #1;
        chk(op_b_out, imm_in);
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk_in);
            fv[i] = $random(seed);
            fpr_we_in <= 1'b1;
            fpr_rt_in <= 5'(i);
            fpr_wd_in <= fv[i];
        end
        // double request with a write of the same cycle: write must be dropped
        @(posedge mclk_in);
        fpr_rt_in <= 5'h05;
        fpr_wd_in <= ~fv[5];
        fp_valid_in <= 1'b1;
        fp_double_in <= 1'b1;
        @(posedge mclk_in);
        fpr_we_in <= 1'b0;
        fp_valid_in <= 1'b0;
        fp_double_in <= 1'b0;
        #1;
        chk({31'h0, fp_trap_out}, 32'h1);
        @(posedge mclk_in);
        #1;
        chk({31'h0, fp_trap_out}, 32'h0);
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk_in);
            fpr_ra_in <= 5'(i);
            fpr_rb_in <= 5'(31 - i);
            @(posedge mclk_in);
            #1;
            chk(fpr_a_out, fv[i]);
            chk(fpr_b_out, fv[31 - i]);
        end
        exp = 32'h0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk_in);
            cr_we_in <= (i == 0) ? 8'hff : 8'($random(seed));
            cr_wd_in <= $random(seed);
            @(posedge mclk_in);
            cr_we_in <= 8'h00;
            exp = crm(exp, cr_we_in, cr_wd_in);
            #1;
            chk(cr_out, exp);
        end
        bus(1'b0, `CARS_ADDR_CR, 32'h0, exp);
        @(posedge mclk_in);
        float_status_ctrl_we_in <= 1'b1;
        float_status_ctrl_wd_in <= $random(seed);
        @(posedge mclk_in);
        float_status_ctrl_we_in <= 1'b0;
        #1;
        chk(float_status_ctrl_out, float_status_ctrl_wd_in);
        bus(1'b0, `CARS_ADDR_FLOAT_STATUS_CTRL, 32'h0, float_status_ctrl_wd_in);
        @(posedge mclk_in);
        exc_take_in <= 1'b1;
        msr_exc_in <= $random(seed) & ~USER;
        @(posedge mclk_in);
        exc_take_in <= 1'b0;
        exc_return_in <= 1'b1;
        #1;
        chk(msr_out, msr_exc_in);
        @(posedge mclk_in);
        exc_return_in <= 1'b0;
        #1;
        chk(msr_out, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk_in);
            sv[i] = $random(seed);
            sr_we_in <= 1'b1;
            sr_idx_in <= 4'(i);
            sr_wd_in <= sv[i];
        end
        @(posedge mclk_in);
        sr_we_in <= 1'b0;
        iseg_idx_in <= 4'hf;
        dseg_idx_in <= 4'hf;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk_in);
            iseg_idx_in <= 4'(i);
            dseg_idx_in <= 4'(15 - i);
            @(posedge mclk_in);
            #1;
            chk(iseg_out, sv[i]);
            chk(dseg_out, sv[15 - i]);
        end
        bus(1'b0, 8'h4c, 32'h0, sv[3]);
        exp = $random(seed);
        bus(1'b1, 8'h44, exp, 32'h0);
        bus(1'b0, 8'h44, 32'h0, exp);
        bus(1'b1, `CARS_ADDR_SAVE, ~exp, 32'h0);
        bus(1'b0, `CARS_ADDR_SAVE, 32'h0, ~exp);
        @(posedge mclk_in);
        msr_we_in <= 1'b1;
        msr_wd_in <= USER;
        @(posedge mclk_in);
        msr_we_in <= 1'b0;
        sr_we_in <= 1'b1;
        sr_idx_in <= 4'h2;
        sr_wd_in <= ~sv[2];
        iseg_idx_in <= 4'h2;
        #1;
        chk({31'h0, supervisor_out}, 32'h0);
        @(posedge mclk_in);
        sr_we_in <= 1'b0;
        #1;
        chk({31'h0, priv_fault_out}, 32'h1);
        bus(1'b1, `CARS_ADDR_MSR, 32'h0, 32'h0);
        chk(msr_out, USER);
        chk(iseg_out, sv[2]);
        @(posedge mclk_in);
        msr_we_in <= 1'b1;
        msr_wd_in <= 32'h0;
        @(posedge mclk_in);
        msr_we_in <= 1'b0;
        #1;
        chk({31'h0, priv_fault_out}, 32'h1);
        chk(msr_out, USER);
        @(posedge mclk_in);
        exc_take_in <= 1'b1;
        msr_exc_in <= 32'h0;
        @(posedge mclk_in);
        exc_take_in <= 1'b0;
        #1;
        chk({31'h0, supervisor_out}, 32'h1);
        bus(1'b0, `CARS_ADDR_STAT, 32'h0, STAT_ALL);
        bus(1'b1, `CARS_ADDR_STAT, STAT_ALL, 32'h0);
        bus(1'b0, `CARS_ADDR_STAT, 32'h0, 32'h0);
        bus(1'b0, 8'h20, 32'h0, 32'h0);
        print_verdict();
    end
endmodule
